/* File: shared/csfpm_pkg.sv */
// constants shared by the clock switch, fail-safe and power mode controller
// assumes one clock domain and register access over an ahb-lite slave port
//
// Notes on behaviour
// (R1) switching and fail-safe monitor run only when the enable config bit is zero
// (R2) while switching is off, the new selection is ignored; status shows initial config
// (R3) while switching is off, the switch request does nothing and reads zero
// (R4) software unlocks before writing the new selection and again before requesting; the controller has no write lock and takes both writes directly
// (R5) a request to the source already running clears itself and aborts
// (R6) a valid switch start clears the pll lock and clock fail flags
// (R7) wait for startup timer on crystals and pll lock on pll sources
// (R8) count ten new-clock cycles once the new source is ready
// (R9) on completion clear the request and copy selection into current status
// (R10) old source turns off, except low-power rc or enabled secondary oscillator
// (R11) software never switches directly between the two pll modes
// (R12) the processor keeps running while a switch is in progress
// (R13) with the monitor on, low-power rc runs except in sleep, watchdog cannot stop it
// (R14) an oscillator failure raises a trap and falls back to fast rc
// (R15) a failure while on pll falls back to fast rc with pll
// (R16) sleep stops clocks and cpu, monitor idle, low-power rc only for watchdog
// (R17) idle stops the cpu only; low-power rc kept for watchdog or monitor
// (R18) watchdog cleared on sleep or idle entry when it is enabled
// (R19) wake on enabled interrupt, reset or watchdog time-out
// (R20) sleep wake keeps the clock source active before sleep
// (R21) idle wake restarts the cpu at once
// (R22) an interrupt during the power-save instruction waits until entry completes
// (R23) the clock fail flag sets on failure and holds until a valid switch

package csfpm_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OSC_CONTROL_OFS = 8'h00;
  localparam logic [7:0] CONFIG_OFS = 8'h04;
  localparam logic [7:0] POWER_SAVE_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;

  // ---------------------------------------------------------------
  // osc_control_reg fields
  // ---------------------------------------------------------------
  localparam int CUR_SRC_LSB = 12;
  localparam int NEW_SRC_LSB = 8;
  localparam int LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SEC_EN_BIT = 1;
  localparam int REQ_BIT = 0;

  // config register fields and reset values
  localparam int CFG_SWMON_BIT = 0;
  localparam int CFG_INIT_LSB = 4;
  localparam int CFG_PRI_LSB = 8;
  localparam logic CFG_SWMON_RST = 1'b1;
  localparam logic [2:0] CFG_INIT_RST = 3'h7;
  localparam logic [1:0] CFG_PRI_RST = 2'h0;

  // power-save command codes
  localparam logic [0:0] PSAVE_SLEEP = 1'h0;
  localparam logic [0:0] PSAVE_IDLE = 1'h1;

  // settle count on the new clock
  localparam int SETTLE_CYCLES = 10;

  // ---------------------------------------------------------------
  // clock sources and state types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_FRC = 3'h0, SRC_FRC_PLL = 3'h1, SRC_PRI = 3'h2, SRC_PRI_PLL = 3'h3,
    SRC_SEC = 3'h4, SRC_LOW_POWER_RC_OSC = 3'h5, SRC_FRC_DIV16 = 3'h6, SRC_FRC_DIVN = 3'h7
  } csfpm_src_t;

  typedef enum logic [2:0] {
    SW_IDLE = 3'h1, SW_WAIT = 3'h2, SW_SETTLE = 3'h4
  } csfpm_sw_t;

  typedef enum logic [2:0] {
    PWR_RUN = 3'h1, PWR_SLEEP = 3'h2, PWR_IDLE = 3'h4
  } csfpm_pwr_t;

endpackage

/* File: hw/csfpm_ctrl.sv */
// clock source switch controller with fail-safe monitor and sleep/idle modes
// assumes oscillator status inputs synchronous to hclk and a single ahb-lite master
`timescale 1ns/1ps

module csfpm_ctrl #(
  parameter int SETTLE = csfpm_pkg::SETTLE_CYCLES // new-clock cycles before handover
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic hsel, // slave select
  input wire logic [7:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic [4:0] osc_ready, // pri, sec, frc, low_power_rc_osc, pll running and timer expired
  input wire logic pll_locked, // pll lock detector
  input wire logic new_clk_tick, // one pulse per cycle of the incoming source
  input wire logic osc_fail, // failure seen by the fail-safe monitor
  input wire logic wdt_enable, // watchdog enabled
  input wire logic wdt_timeout, // watchdog expired
  input wire logic irq_wake, // an individually enabled interrupt is pending
  output logic [2:0] sys_clk_sel, // source driving the system clock
  output logic [4:0] osc_enable, // pri, sec, frc, low_power_rc_osc, pll enables
  output logic clk_fail_trap, // trap, high one cycle after each cycle of fail_event
  output logic wdt_clear, // one-cycle watchdog clear
  output logic cpu_halt, // cpu clock stopped
  output logic sys_clk_run, // system clock running
  output logic wake_pulse // one-cycle wake event
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  // the settle counter is four bits wide, so longer settles cannot be served
  if (SETTLE < 1 || SETTLE > 15) begin : g_settle_check
    $error("SETTLE must be 1 to 15");
  end

  localparam int OSC_PRI = 0;
  localparam int OSC_SEC = 1;
  localparam int OSC_FRC = 2;
  localparam int OSC_LOW_POWER_RC_OSC = 3;
  localparam int OSC_PLL = 4;

  // ---------------------------------------------------------------
  // ahb-lite slave front end
  // ---------------------------------------------------------------
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic addr_ok;
  logic wr_take;
  logic rd_take;

  assign addr_ok = hsel && hready && htrans[1];
  assign wr_take = addr_ok && hwrite;
  assign rd_take = addr_ok && !hwrite;
  assign hreadyout = 1'b1; // zero wait states on every access
  assign hresp = 1'b0;

  // capture the address phase of a write for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_take;
      if (wr_take) begin
        wr_addr_q <= haddr;
      end
    end
  end

  logic wr_osc;
  logic wr_cfg;
  logic wr_psave;
  assign wr_osc = wr_pend_q && (wr_addr_q == csfpm_pkg::OSC_CONTROL_OFS);
  assign wr_cfg = wr_pend_q && (wr_addr_q == csfpm_pkg::CONFIG_OFS);
  assign wr_psave = wr_pend_q && (wr_addr_q == csfpm_pkg::POWER_SAVE_OFS);

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  logic swmon_cfg_q;
  logic [2:0] init_src_q;
  logic [1:0] pri_mode_q;
  logic sw_en;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      swmon_cfg_q <= csfpm_pkg::CFG_SWMON_RST;
      init_src_q <= csfpm_pkg::CFG_INIT_RST;
      pri_mode_q <= csfpm_pkg::CFG_PRI_RST;
    end else if (wr_cfg) begin
      swmon_cfg_q <= hwdata[csfpm_pkg::CFG_SWMON_BIT];
      init_src_q <= hwdata[csfpm_pkg::CFG_INIT_LSB +: 3];
      pri_mode_q <= hwdata[csfpm_pkg::CFG_PRI_LSB +: 2];
    end
  end

  // active when programmed to zero
  assign sw_en = !swmon_cfg_q; // R1

  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  csfpm_pkg::csfpm_sw_t sw_q;
  csfpm_pkg::csfpm_pwr_t pwr_q;
  logic [2:0] cur_src_q;
  logic [2:0] new_src_q;
  logic [2:0] tgt_src_q;
  logic [2:0] old_src_q;
  logic req_q;
  logic lock_q;
  logic fail_q;
  logic sec_en_q;
  logic [3:0] settle_q;
  logic sleeping;
  logic fail_event;
  logic sw_start;
  logic sw_abort;
  logic sw_done;
  logic tgt_ready;

  assign sleeping = (pwr_q == csfpm_pkg::PWR_SLEEP);
  // monitor is blind in sleep since the system clock is stopped
  assign fail_event = sw_en && osc_fail && !sleeping; // R14 R16
  assign sw_start = (sw_q == csfpm_pkg::SW_IDLE) && req_q && sw_en && !sleeping &&
                    (new_src_q != cur_src_q) && !fail_event;
  assign sw_abort = (sw_q == csfpm_pkg::SW_IDLE) && req_q && sw_en &&
                    (new_src_q == cur_src_q); // R5
  assign sw_done = (sw_q == csfpm_pkg::SW_SETTLE) && new_clk_tick &&
                   (settle_q == 4'(SETTLE - 1)) && sw_en && !sleeping && !fail_event;

  // ---------------------------------------------------------------
  // readiness of the new source
  // ---------------------------------------------------------------
  always_comb begin
    case (tgt_src_q)
      csfpm_pkg::SRC_PRI: tgt_ready = osc_ready[OSC_PRI]; // R7
      csfpm_pkg::SRC_PRI_PLL: tgt_ready = osc_ready[OSC_PRI] && pll_locked; // R7
      csfpm_pkg::SRC_FRC_PLL: tgt_ready = osc_ready[OSC_FRC] && pll_locked; // R7
      csfpm_pkg::SRC_SEC: tgt_ready = osc_ready[OSC_SEC]; // R7
      csfpm_pkg::SRC_LOW_POWER_RC_OSC: tgt_ready = osc_ready[OSC_LOW_POWER_RC_OSC];
      default: tgt_ready = osc_ready[OSC_FRC];
    endcase
  end

  // ---------------------------------------------------------------
  // switch sequencer; cpu keeps running meanwhile, nothing here halts it
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin // R12
    if (!hresetn) begin
      sw_q <= csfpm_pkg::SW_IDLE;
      settle_q <= 4'h0;
      tgt_src_q <= 3'h0;
    end else begin
      case (sw_q)
        csfpm_pkg::SW_IDLE: begin
          settle_q <= 4'h0;
          if (sw_start) begin
            tgt_src_q <= new_src_q; // later writes do not move the target
            sw_q <= csfpm_pkg::SW_WAIT;
          end
        end
        csfpm_pkg::SW_WAIT: begin
          if (fail_event || !sw_en) begin
            sw_q <= csfpm_pkg::SW_IDLE;
          end else if (tgt_ready && !sleeping) begin
            sw_q <= csfpm_pkg::SW_SETTLE;
          end
        end
        csfpm_pkg::SW_SETTLE: begin
          if (fail_event || !sw_en || sw_done) begin
            sw_q <= csfpm_pkg::SW_IDLE;
          end else if (new_clk_tick && !sleeping) begin
            settle_q <= settle_q + 4'h1; // R8
          end
        end
        default: sw_q <= csfpm_pkg::SW_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // current source; sleep never touches it so wake resumes on it
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin // R20
    if (!hresetn) begin
      cur_src_q <= csfpm_pkg::CFG_INIT_RST;
      old_src_q <= csfpm_pkg::CFG_INIT_RST;
    end else if (!sw_en) begin
      cur_src_q <= init_src_q; // R2
      old_src_q <= init_src_q;
    end else if (fail_event) begin
      old_src_q <= cur_src_q;
      if (cur_src_q == csfpm_pkg::SRC_PRI_PLL || cur_src_q == csfpm_pkg::SRC_FRC_PLL) begin
        cur_src_q <= csfpm_pkg::SRC_FRC_PLL; // R15
      end else begin
        cur_src_q <= csfpm_pkg::SRC_FRC; // R14
      end
    end else if (sw_done) begin
      old_src_q <= cur_src_q;
      cur_src_q <= tgt_src_q; // R9
    end
  end

  // ---------------------------------------------------------------
  // oscillator control fields
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      new_src_q <= csfpm_pkg::CFG_INIT_RST;
      sec_en_q <= 1'b0;
    end else if (wr_osc) begin
      new_src_q <= hwdata[csfpm_pkg::NEW_SRC_LSB +: 3];
      sec_en_q <= hwdata[csfpm_pkg::SEC_EN_BIT];
    end
  end

  // request sets on a write of one; hardware clears it on abort or completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= 1'b0;
    end else if (!sw_en) begin
      req_q <= 1'b0; // R3
    end else if (sw_abort || sw_done) begin
      req_q <= 1'b0; // R5 R9
    end else if (wr_osc && hwdata[csfpm_pkg::REQ_BIT]) begin
      req_q <= 1'b1;
    end
  end

  // lock and fail flags: a fail set in the clearing cycle wins; for lock the clear at switch start wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      if (pll_locked && osc_enable[OSC_PLL] && !sw_start) begin
        lock_q <= 1'b1;
      end else if (sw_start || !osc_enable[OSC_PLL]) begin
        lock_q <= 1'b0; // R6
      end
      if (fail_event) begin
        fail_q <= 1'b1; // R23
      end else if (sw_start) begin
        fail_q <= 1'b0; // R6
      end
    end
  end

  // ---------------------------------------------------------------
  // power modes; a wake check only in sleep or idle defers coincident interrupts
  // ---------------------------------------------------------------
  logic wake;
  assign wake = irq_wake || wdt_timeout; // R19

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_q <= csfpm_pkg::PWR_RUN;
    end else begin
      case (pwr_q)
        csfpm_pkg::PWR_RUN: begin
          if (wr_psave && hwdata[0] == csfpm_pkg::PSAVE_SLEEP) begin
            pwr_q <= csfpm_pkg::PWR_SLEEP; // R16
          end else if (wr_psave) begin
            pwr_q <= csfpm_pkg::PWR_IDLE; // R17
          end
        end
        csfpm_pkg::PWR_SLEEP, csfpm_pkg::PWR_IDLE: begin
          if (wake) begin
            pwr_q <= csfpm_pkg::PWR_RUN; // R19 R21 R22
          end
        end
        default: pwr_q <= csfpm_pkg::PWR_RUN;
      endcase
    end
  end

  // watchdog clear and wake pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_clear <= 1'b0;
      wake_pulse <= 1'b0;
      clk_fail_trap <= 1'b0;
    end else begin
      wdt_clear <= wr_psave && (pwr_q == csfpm_pkg::PWR_RUN) && wdt_enable; // R18
      wake_pulse <= (pwr_q != csfpm_pkg::PWR_RUN) && wake;
      clk_fail_trap <= fail_event; // R14
    end
  end

  assign cpu_halt = (pwr_q != csfpm_pkg::PWR_RUN); // R16 R17 R21
  assign sys_clk_run = !sleeping; // R17
  assign sys_clk_sel = cur_src_q;

  // ---------------------------------------------------------------
  // oscillator enables; a source is on while in use or being switched to
  // ---------------------------------------------------------------
  logic [2:0] use_a;
  logic [2:0] use_b;
  logic use_b_v;
  assign use_a = cur_src_q;
  assign use_b = tgt_src_q;
  assign use_b_v = (sw_q != csfpm_pkg::SW_IDLE);

  function automatic logic [4:0] src_oscs(input logic [2:0] s);
    logic [4:0] v;
    v = 5'h00;
    case (s)
      csfpm_pkg::SRC_PRI: v[OSC_PRI] = 1'b1;
      csfpm_pkg::SRC_PRI_PLL: v = 5'h11;
      csfpm_pkg::SRC_FRC_PLL: v = 5'h14;
      csfpm_pkg::SRC_SEC: v[OSC_SEC] = 1'b1;
      csfpm_pkg::SRC_LOW_POWER_RC_OSC: v[OSC_LOW_POWER_RC_OSC] = 1'b1;
      default: v[OSC_FRC] = 1'b1;
    endcase
    return v;
  endfunction

  // old source drops as soon as cur moves on
  always_comb begin // R10
    osc_enable = src_oscs(use_a) | (use_b_v ? src_oscs(use_b) : 5'h00);
    if (sleeping) begin
      osc_enable = 5'h00; // R16
    end
    if (sec_en_q) begin
      osc_enable[OSC_SEC] = 1'b1; // R10
    end
    if (wdt_enable || (sw_en && !sleeping)) begin
      osc_enable[OSC_LOW_POWER_RC_OSC] = 1'b1; // R13 R16 R17
    end
  end

  // ---------------------------------------------------------------
  // read data, registered in the address phase
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr)
      csfpm_pkg::OSC_CONTROL_OFS: begin
        rd_mux[csfpm_pkg::CUR_SRC_LSB +: 3] = cur_src_q; // R2
        rd_mux[csfpm_pkg::NEW_SRC_LSB +: 3] = new_src_q;
        rd_mux[csfpm_pkg::LOCK_BIT] = lock_q;
        rd_mux[csfpm_pkg::FAIL_BIT] = fail_q;
        rd_mux[csfpm_pkg::SEC_EN_BIT] = sec_en_q;
        rd_mux[csfpm_pkg::REQ_BIT] = req_q && sw_en; // R3
      end
      csfpm_pkg::CONFIG_OFS: begin
        rd_mux[csfpm_pkg::CFG_SWMON_BIT] = swmon_cfg_q;
        rd_mux[csfpm_pkg::CFG_INIT_LSB +: 3] = init_src_q;
        rd_mux[csfpm_pkg::CFG_PRI_LSB +: 2] = pri_mode_q;
      end
      csfpm_pkg::STATUS_OFS: begin
        rd_mux[2:0] = pwr_q;
        rd_mux[6:4] = sw_q;
        rd_mux[12:8] = osc_enable;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_req_off_disabled: assert property (!sw_en |-> !rd_mux[0] || haddr != 8'h00) // R3
    else $error("switch request visible while switching disabled");
  a_cur_follows_cfg: assert property (!sw_en |=> cur_src_q == $past(init_src_q)) // R2
    else $error("current source not from initial config");
  a_abort_clears: assert property (sw_abort |=> !req_q && sw_q == csfpm_pkg::SW_IDLE) // R5
    else $error("redundant switch not aborted");
  a_start_clears_fail: assert property (sw_start && !fail_event |=> !fail_q && !lock_q) // R6
    else $error("flags not cleared at switch start");
  a_pll_waits_lock: assert property (sw_q == csfpm_pkg::SW_WAIT && !pll_locked && // R7
      (tgt_src_q == csfpm_pkg::SRC_FRC_PLL || tgt_src_q == csfpm_pkg::SRC_PRI_PLL)
      |=> sw_q != csfpm_pkg::SW_SETTLE)
    else $error("left wait without pll lock");
  a_done_copies: assert property (sw_done |=> cur_src_q == $past(tgt_src_q) && !req_q) // R9
    else $error("completion did not copy selection");
  a_fail_frc: assert property (fail_event && !(cur_src_q inside {3'h1, 3'h3}) |=> // R14
      cur_src_q == csfpm_pkg::SRC_FRC && clk_fail_trap)
    else $error("failure did not fall back to fast rc");
  a_fail_pll: assert property (fail_event && cur_src_q == csfpm_pkg::SRC_PRI_PLL |=> // R15
      cur_src_q == csfpm_pkg::SRC_FRC_PLL)
    else $error("pll failure did not fall back to fast rc with pll");
  a_fail_sticky: assert property (fail_q && !sw_start |=> fail_q) // R23
    else $error("clock fail flag dropped without a switch");
  a_low_power_rc_osc_mon: assert property (sw_en && !sleeping |-> osc_enable[OSC_LOW_POWER_RC_OSC]) // R13
    else $error("low-power rc stopped with monitor on");
  a_sleep_off: assert property (sleeping && !wdt_enable && !sec_en_q |-> osc_enable == 5'h00) // R16
    else $error("oscillator left on in sleep");
  a_wdt_clear: assert property (wr_psave && pwr_q == csfpm_pkg::PWR_RUN && wdt_enable // R18
      |=> wdt_clear ##1 !wdt_clear)
    else $error("watchdog not cleared on entry");
  a_wake_run: assert property (cpu_halt && wake |=> !cpu_halt && wake_pulse) // R19
    else $error("no wake on event");
  a_defer_irq: assert property (wr_psave && pwr_q == csfpm_pkg::PWR_RUN |=> cpu_halt) // R22
    else $error("entry skipped by coincident interrupt");
  a_sleep_keeps: assert property (sleeping |=> $stable(cur_src_q)) // R20
    else $error("source changed during sleep");

  c_switch_done: cover property (sw_done);
  c_fail_trap: cover property (clk_fail_trap);
  c_sleep_wake: cover property (sleeping ##1 wake_pulse);
  c_idle_wake: cover property (pwr_q == csfpm_pkg::PWR_IDLE ##1 wake_pulse);

endmodule

/* File: bench/csfpm_ctrl_bench.sv */
// self-checking bench for the clock switch, fail-safe and power mode controller
// assumes the controller answers ahb-lite with zero waits and one hclk domain
`timescale 1ns/1ps

module csfpm_ctrl_bench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, sys_clk_sel;
  logic [31:0] hwdata, hrdata, rd;
  logic [4:0] osc_ready, osc_enable;
  logic pll_locked, new_clk_tick, osc_fail, wdt_enable, wdt_timeout, irq_wake;
  logic clk_fail_trap, wdt_clear, cpu_halt, sys_clk_run, wake_pulse;
  int failures = 0, total_checks = 0, cycles = 0, n_trap = 0, n_clr = 0, n_wake = 0;

  csfpm_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_ready(osc_ready),
    .pll_locked(pll_locked), .new_clk_tick(new_clk_tick), .osc_fail(osc_fail),
    .wdt_enable(wdt_enable), .wdt_timeout(wdt_timeout), .irq_wake(irq_wake),
    .sys_clk_sel(sys_clk_sel), .osc_enable(osc_enable), .clk_fail_trap(clk_fail_trap),
    .wdt_clear(wdt_clear), .cpu_halt(cpu_halt), .sys_clk_run(sys_clk_run),
    .wake_pulse(wake_pulse));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // clock at 125 MHz
  initial begin
    hclk = 0;
    forever #4 hclk = ~hclk;
  end

  // pulse counters, so one-cycle outputs are never missed; hang guard
  always @(posedge hclk) begin
    n_trap += (clk_fail_trap === 1'b1);
    n_clr += (wdt_clear === 1'b1);
    n_wake += (wake_pulse === 1'b1);
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one single ahb-lite transfer; master waits on hready, no fixed latency
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk("hresp", hresp, 0);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge hclk) new_clk_tick <= 1;
      @(posedge hclk) new_clk_tick <= 0;
    end
  endtask

  task automatic fail_once(input logic [2:0] exp);
    int t0;
    t0 = n_trap;
    @(posedge hclk) osc_fail <= 1;
    @(posedge hclk) osc_fail <= 0;
    #1 chk("fallback_src", sys_clk_sel, exp);
    bus(8'h00, 0, 0);
    chk("trap_count", n_trap, t0 + 1);
    chk("fail_flag", rd[3], 1);
  endtask

  // full switch: settle must need exactly ten ticks, flags cleared at start
  task automatic switch_to(input logic [2:0] src, input logic [2:0] old);
    bus(8'h00, 1, {21'h0, src, 8'h00});
    bus(8'h00, 1, {21'h0, src, 8'h01});
    repeat (3) @(posedge hclk);
    bus(8'h00, 0, 0);
    // fail cleared at start; a pll target shows lock again once the wait saw it
    chk("flags_clear", {rd[5], rd[3]}, {src == 3'h3, 1'b0});
    ticks(9);
    #1 chk("before_tenth", sys_clk_sel, old);
    ticks(1);
    #1 chk("after_tenth", sys_clk_sel, src);
    bus(8'h00, 0, 0);
    chk("status_req", {rd[14:12], rd[0]}, {src, 1'b0});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_disabled();
    bus(8'h00, 1, 32'h0201);
    ticks(12);
    bus(8'h00, 0, 0);
    chk("dis_status", {rd[14:12], rd[0]}, 4'he);
    chk("dis_sel", sys_clk_sel, 7);
    osc_fail <= 1;
    repeat (3) @(posedge hclk);
    osc_fail <= 0;
    bus(8'h10, 0, 0);
    chk("unmapped", rd, 0);
    chk("dis_trap", n_trap, 0);
  endtask

  task automatic t_switches();
    bus(8'h04, 1, 32'h70);
    bus(8'h00, 1, 32'h0701);
    repeat (2) @(posedge hclk);
    bus(8'h00, 0, 0);
    chk("redundant", {rd[14:12], rd[0]}, 4'he);
    bus(8'h00, 1, 32'h0201);
    repeat (6) @(posedge hclk);
    ticks(10);
    chk("wait_ready", sys_clk_sel, 7);
    osc_ready[0] <= 1;
    switch_to(3'h2, 3'h7);
    chk("old_off", {osc_enable[3], osc_enable[2], osc_enable[0]}, 3'h5);
    fail_once(3'h0);
    osc_ready <= 5'h1f;
    pll_locked <= 1;
    switch_to(3'h3, 3'h0);
    fail_once(3'h1);
  endtask

  task automatic t_power();
    logic [2:0] src;
    src = sys_clk_sel;
    wdt_enable <= 1;
    bus(8'h08, 1, 0);
    @(posedge hclk) #1;
    chk("sleep_state", {cpu_halt, sys_clk_run, osc_enable}, 7'h48);
    chk("sleep_clear", n_clr, 1);
    wdt_timeout <= 1;
    repeat (2) @(posedge hclk);
    wdt_timeout <= 0;
    #1 chk("sleep_wake", {cpu_halt, sys_clk_sel}, {1'b0, src});
    irq_wake <= 1;
    bus(8'h08, 1, 1);
    @(posedge hclk) irq_wake <= 0;
    chk("idle_state", {cpu_halt, sys_clk_run}, 2'h3);
    @(posedge hclk) #1;
    chk("idle_wake", {cpu_halt, sys_clk_run}, 2'h1);
    chk("wake_count", n_wake, 2);
    chk("idle_clear", n_clr, 2);
  endtask

  // ---------------------------------------------------------------
  // main sequence and verdict
  // ---------------------------------------------------------------
  task automatic close_out();
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    hresetn = 0;
    {hsel, hwrite, new_clk_tick, osc_fail, wdt_enable, wdt_timeout, irq_wake} = 0;
    {haddr, htrans, hwdata, pll_locked} = 0;
    hready = 1;
    hsize = 3'h2;
    osc_ready = 5'h0c;
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    t_disabled();
    t_switches();
    t_power();
    close_out();
  end
endmodule
